// *** hw/macdp_core.sv ***
// multiply-accumulate datapath: sequencer, operand addressing, move and result stream
`timescale 1ns/1ps
module macdp_core
    import macdp_pkg::*;
#(
    parameter int FIFO_DEPTH = MACDP_FIFO_D
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        cmdValid,
    input  wire macdp_cmd_t  cmd,
    output logic             cmdReady,
    input  wire logic [1:0]  productShiftMode,
    input  wire logic        overflowSaturateMode,
    input  wire logic        overflowClear,
    input  wire logic        auxWrEn,
    input  wire logic [2:0]  auxWrIdx,
    input  wire logic [15:0] auxWrData,
    output logic [15:0]      pmAddr,
    output logic             pmRd,
    input  wire logic [15:0] pmData,
    input  wire logic        pmRdy,
    output logic [15:0]      dmAddr,
    output logic             dmRd,
    input  wire logic [15:0] dmData,
    input  wire logic        dmRdy,
    output logic             dmWrEn,
    output logic [15:0]      dmWrAddr,
    output logic [15:0]      dmWrData,
    output logic             resValid,
    input  wire logic        resReady,
    output logic [31:0]      resData,
    output logic [31:0]      accumulator,
    output logic [31:0]      product,
    output logic [15:0]      multiplicand,
    output logic             carryFlag,
    output logic             overflowFlag,
    output logic [2:0]       auxRegPointer,
    output logic [15:0]      microStack,
    output logic             done
);
    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STEP, S_FINISH} macdp_state_t;

    macdp_state_t           state_reg;
    macdp_state_t           state_next;
    macdp_cmd_t             cmd_reg;
    logic [15:0]            auxReg [8];
    logic [MACDP_RPT_W-1:0] rptCnt_reg;
    logic [1:0]             waitCnt_reg;
    logic [1:0]             waitLoad;
    logic [31:0]            accumulator_reg;
    logic [31:0]            product_reg;
    logic [15:0]            multiplicand_reg;
    logic [15:0]            programCounter_reg;
    logic [15:0]            microStack_reg;
    logic [15:0]            dmAddr_reg;
    logic [2:0]             auxRegPointer_reg;
    logic                   carry_reg;
    logic                   overflow_reg;
    logic                   dmWrEn_reg;
    logic [15:0]            dmWrAddr_reg;
    logic [15:0]            dmWrData_reg;
    logic                   done_reg;
    logic                   rd_reg;
    logic                   cmdReady_reg;
    macdp_sum_t             sumRes;
    logic                   fifoInReady;
    logic                   accepted;
    logic                   stepGo;
    logic                   lastStep;
    logic                   moveEn;
    logic                   repeated;
    logic [15:0]            curAux;
    logic [15:0]            updAux;
    logic [2:0]             nextPtr;
    logic [15:0]            nextIndAddr;
    logic [15:0]            directAddr;
    logic [31:0]            mulRes;

    // reverse-carry arithmetic for fft addressing
    function automatic logic [15:0] bitRev(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    // auxiliary register update for the indirect modes
    function automatic logic [15:0] auxStep(input logic [15:0] cur, input logic [15:0] ofs,
                                            input logic [2:0] code);
        logic [15:0] r;
        r = cur;
        case (code)
            MACDP_AUX_DEC:   r = cur - 16'h0001;
            MACDP_AUX_INC:   r = cur + 16'h0001;
            MACDP_AUX_SUB0:  r = cur - ofs;
            MACDP_AUX_ADD0:  r = cur + ofs;
            MACDP_AUX_BRSUB: r = bitRev(bitRev(cur) - bitRev(ofs));
            MACDP_AUX_BRADD: r = bitRev(bitRev(cur) + bitRev(ofs));
            default:         r = cur;
        endcase
        return r;
    endfunction

    // extra stall cycles for a step: same-block conflicts and the move write
    function automatic logic [1:0] stepExtra(input macdp_cmd_t c, input logic edgeStep);
        logic [1:0] e;
        logic       mv;
        mv = (c.rptCount != '0) && c.op2Single && (c.op == MACDP_MUL_ACC_MOVE);
        e  = {1'b0, c.sameBlock} + {1'b0, mv};
        if (mv && edgeStep) begin
            e = e - 2'h1;
        end
        return e;
    endfunction

    // the move source is range-checked: only an address inside on-chip ram enables the move write
    function automatic logic isOnChipRam(input logic [15:0] a);
        return (a >= MACDP_RAM_LO) && (a <= MACDP_RAM_HI);
    endfunction

    macdp_accum u_accum (
        .acc       (accumulator_reg),
        .product   (product_reg),
        .shiftMode (productShiftMode),
        .satMode   (overflowSaturateMode),
        .result    (sumRes)
    );

    // each accumulated value is streamed out; a full fifo stalls the step
    macdp_fifo #(.W(MACDP_PW), .D(FIFO_DEPTH)) u_fifo (
        .clk      (clk),
        .rst_b    (rst_b),
        .inValid  (stepGo),
        .inReady  (fifoInReady),
        .inData   (sumRes.acc),
        .outValid (resValid),
        .outReady (resReady),
        .outData  (resData)
    );

    // step decode and operand address selection
    assign accepted    = (state_reg == S_IDLE) && cmdValid;
    assign stepGo      = (state_reg == S_STEP) && (waitCnt_reg == 2'h0) && pmRdy && dmRdy
                         && fifoInReady;
    assign lastStep    = (rptCnt_reg == '0);
    assign repeated    = (cmd_reg.rptCount != '0);
    assign moveEn      = (cmd_reg.op == MACDP_MUL_ACC_MOVE) && isOnChipRam(dmAddr_reg);
    assign curAux      = auxReg[auxRegPointer_reg];
    assign updAux      = auxStep(curAux, auxReg[0], cmd_reg.auxUpdate);
    assign nextPtr     = cmd_reg.loadPtr ? cmd_reg.nextAux : auxRegPointer_reg;
    assign nextIndAddr = (nextPtr == auxRegPointer_reg) ? updAux : auxReg[nextPtr];
    assign directAddr  = {cmd.dataPage, cmd.dma};
    assign mulRes      = 32'($signed(dmData) * $signed(pmData));
    assign waitLoad    = (state_reg == S_SETUP)
                         ? stepExtra(cmd_reg, 1'b1)
                         : stepExtra(cmd_reg, rptCnt_reg == {{(MACDP_RPT_W-1){1'b0}}, 1'b1});

    // sequencer: setup, n steps, restore
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:   state_next = cmdValid ? S_SETUP : S_IDLE;
            S_SETUP:  state_next = S_STEP;
            S_STEP:   state_next = (stepGo && lastStep) ? S_FINISH : S_STEP;
            S_FINISH: state_next = S_IDLE;
            default:  state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg    <= S_IDLE;
            cmd_reg      <= '0;
            cmdReady_reg <= 1'b1;
        end else begin
            state_reg    <= state_next;
            cmdReady_reg <= (state_next == S_IDLE);
            if (accepted) begin
                cmd_reg <= cmd;
            end
        end
    end

    // repeat counter and per-step stall counter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rptCnt_reg  <= '0;
            waitCnt_reg <= 2'h0;
        end else if (accepted) begin
            rptCnt_reg <= cmd.rptCount;
        end else if (state_reg == S_SETUP || stepGo) begin
            waitCnt_reg <= waitLoad;
            if (stepGo) begin
                rptCnt_reg <= rptCnt_reg - 1'b1;
            end
        end else if (waitCnt_reg != 2'h0) begin
            waitCnt_reg <= waitCnt_reg - 2'h1;
        end
    end

    // program counter and micro stack
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            programCounter_reg <= MACDP_ZERO16;
            microStack_reg     <= MACDP_ZERO16;
        end else if (state_reg == S_SETUP) begin
            microStack_reg     <= cmd_reg.instrAddr + MACDP_INSTR_LEN;
            programCounter_reg <= cmd_reg.pma;
        end else if (stepGo) begin
            programCounter_reg <= programCounter_reg + 16'h0001;
        end else if (state_reg == S_FINISH) begin
            programCounter_reg <= microStack_reg;
        end
    end

    // data address: constant when direct, follows the aux register when indirect
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dmAddr_reg <= MACDP_ZERO16;
        end else if (accepted) begin
            dmAddr_reg <= cmd.indirect ? auxReg[auxRegPointer_reg] : directAddr;
        end else if (stepGo && cmd_reg.indirect) begin
            dmAddr_reg <= nextIndAddr;
        end
    end

    // auxiliary registers: software loads only while idle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            auxRegPointer_reg <= 3'h0;
            for (int i = 0; i < 8; i++) begin
                auxReg[i] <= MACDP_ZERO16;
            end
        end else if (stepGo && cmd_reg.indirect) begin
            auxReg[auxRegPointer_reg] <= updAux;
            auxRegPointer_reg         <= nextPtr;
        end else if (auxWrEn && state_reg == S_IDLE) begin
            auxReg[auxWrIdx] <= auxWrData;
        end
    end

    // arithmetic registers: accumulate old product, then multiply the new pair
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            accumulator_reg  <= MACDP_ZERO32;
            product_reg      <= MACDP_ZERO32;
            multiplicand_reg <= MACDP_ZERO16;
            carry_reg        <= 1'b0;
        end else if (stepGo) begin
            accumulator_reg  <= sumRes.acc;
            carry_reg        <= sumRes.carry;
            multiplicand_reg <= dmData;
            product_reg      <= mulRes;
        end
    end

    // sticky overflow: a new overflow wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            overflow_reg <= 1'b0;
        end else if (stepGo && sumRes.ovf) begin
            overflow_reg <= 1'b1;
        end else if (overflowClear) begin
            overflow_reg <= 1'b0;
        end
    end

    // data move write, one pulse per step, only when the source address is in on-chip ram
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dmWrEn_reg   <= 1'b0;
            dmWrAddr_reg <= MACDP_ZERO16;
            dmWrData_reg <= MACDP_ZERO16;
            done_reg     <= 1'b0;
            rd_reg       <= 1'b0;
        end else begin
            dmWrEn_reg <= stepGo && moveEn;
            done_reg   <= (state_reg == S_FINISH);
            rd_reg     <= (state_next == S_STEP);
            if (stepGo) begin
                dmWrAddr_reg <= dmAddr_reg + 16'h0001;
                dmWrData_reg <= dmData;
            end
        end
    end

    assign cmdReady      = cmdReady_reg; // a flop so the port carries no decode glitch
    assign pmAddr        = programCounter_reg;
    assign pmRd          = rd_reg;
    assign dmAddr        = dmAddr_reg;
    assign dmRd          = rd_reg;
    assign dmWrEn        = dmWrEn_reg;
    assign dmWrAddr      = dmWrAddr_reg;
    assign dmWrData      = dmWrData_reg;
    assign accumulator   = accumulator_reg;
    assign product       = product_reg;
    assign multiplicand  = multiplicand_reg;
    assign carryFlag     = carry_reg;
    assign overflowFlag  = overflow_reg;
    assign auxRegPointer = auxRegPointer_reg;
    assign microStack    = microStack_reg;
    assign done          = done_reg;

    // helper: cycles since acceptance and whether memory or fifo ever stalled
    logic [9:0] cycCnt_reg;
    logic       stalled_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cycCnt_reg  <= '0;
            stalled_reg <= 1'b0;
        end else if (accepted) begin
            cycCnt_reg  <= 10'h001;
            stalled_reg <= 1'b0;
        end else if (state_reg != S_IDLE) begin
            cycCnt_reg <= cycCnt_reg + 10'h001;
            if (state_reg == S_STEP && !(pmRdy && dmRdy && fifoInReady)) begin
                stalled_reg <= 1'b1;
            end
        end
    end

    accum_add_a: assert property (@(posedge clk) disable iff (!rst_b)
        stepGo |=> accumulator == $past(sumRes.acc)) else $error("accumulate wrong");
    carry_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        stepGo |=> carryFlag == $past(sumRes.carry)) else $error("carry wrong");
    mult_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        stepGo |=> multiplicand == $past(dmData)
                   && product == 32'($signed($past(dmData)) * $signed($past(pmData))))
        else $error("multiply wrong");
    pc_swap_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg == S_SETUP |=> pmAddr == cmd_reg.pma
                   ##[1:600] state_reg == S_IDLE && pmAddr == microStack)
        else $error("pc save or restore wrong");
    rpt_walk_a: assert property (@(posedge clk) disable iff (!rst_b)
        stepGo && !lastStep |=> pmAddr == $past(pmAddr) + 16'h0001
                   && rptCnt_reg == $past(rptCnt_reg) - 1'b1) else $error("repeat step wrong");
    direct_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        stepGo && !cmd_reg.indirect |=> $stable(dmAddr)) else $error("direct addr moved");
    move_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        stepGo |=> dmWrEn == $past(moveEn)
                   && (!dmWrEn || dmWrAddr == $past(dmAddr) + 16'h0001))
        else $error("move write wrong");
    single_time_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg == S_FINISH && !stalled_reg && !repeated && !cmd_reg.sameBlock
        |-> cycCnt_reg == 10'd3) else $error("single run not three cycles");
    rpt_time_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg == S_FINISH && !stalled_reg && repeated && !cmd_reg.sameBlock
        && !cmd_reg.op2Single |-> cycCnt_reg == 10'(cmd_reg.rptCount) + 10'd3)
        else $error("repeat run not n+2");
    conflict_time_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg == S_FINISH && !stalled_reg && cmd_reg.sameBlock
        && cmd_reg.op == MACDP_MUL_ACC |-> cycCnt_reg == 10'(cmd_reg.rptCount) * 10'd2 + 10'd4)
        else $error("conflict run wrong length");
    ovf_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
        stepGo && sumRes.ovf |=> overflowFlag) else $error("overflow not flagged");

    single_run_c: cover property (@(posedge clk) disable iff (!rst_b)
        accepted && cmd.rptCount == '0 ##4 done);
    aux_ptr_c: cover property (@(posedge clk) disable iff (!rst_b)
        stepGo && cmd_reg.indirect && cmd_reg.loadPtr);
    repeat_run_c: cover property (@(posedge clk) disable iff (!rst_b)
        stepGo && !lastStep ##1 stepGo);
    move_run_c: cover property (@(posedge clk) disable iff (!rst_b) dmWrEn);
    fifo_full_c: cover property (@(posedge clk) disable iff (!rst_b)
        state_reg == S_STEP && !fifoInReady);
endmodule

// *** hw/macdp_pkg.sv ***
// shared constants, codes and carriers of the multiply-accumulate datapath
package macdp_pkg;
    localparam int          MACDP_DW        = 16;
    localparam int          MACDP_PW        = 32;
    localparam int          MACDP_RPT_W     = 8;
    localparam int          MACDP_FIFO_D    = 16;
    localparam logic [15:0] MACDP_INSTR_LEN = 16'h0002; // two-word instruction
    localparam logic [15:0] MACDP_RAM_LO    = 16'h0060; // first on-chip ram word
    localparam logic [15:0] MACDP_RAM_HI    = 16'h07ff; // last on-chip ram word
    localparam logic [31:0] MACDP_POS_MAX   = 32'h7fff_ffff;
    localparam logic [31:0] MACDP_NEG_MAX   = 32'h8000_0000;
    localparam logic [15:0] MACDP_ZERO16    = 16'h0000;
    localparam logic [31:0] MACDP_ZERO32    = 32'h0000_0000;
    localparam logic [2:0]  MACDP_AUX_NONE  = 3'h0;
    localparam logic [2:0]  MACDP_AUX_DEC   = 3'h1;
    localparam logic [2:0]  MACDP_AUX_INC   = 3'h2;
    localparam logic [2:0]  MACDP_AUX_BRSUB = 3'h4;
    localparam logic [2:0]  MACDP_AUX_SUB0  = 3'h5;
    localparam logic [2:0]  MACDP_AUX_ADD0  = 3'h6;
    localparam logic [2:0]  MACDP_AUX_BRADD = 3'h7;
    localparam logic [1:0]  MACDP_PM_NONE   = 2'h0;
    localparam logic [1:0]  MACDP_PM_LEFT1  = 2'h1;
    localparam logic [1:0]  MACDP_PM_LEFT4  = 2'h2;
    localparam logic [1:0]  MACDP_PM_RIGHT6 = 2'h3;

    typedef enum logic {MACDP_MUL_ACC, MACDP_MUL_ACC_MOVE} macdp_op_t;

    // one decoded instruction as handed over by the sequencer
    typedef struct packed {
        macdp_op_t               op;
        logic                    indirect;
        logic [6:0]              dma;
        logic [8:0]              dataPage;
        logic [2:0]              auxUpdate;
        logic                    loadPtr;
        logic [2:0]              nextAux;
        logic [15:0]             pma;
        logic [15:0]             instrAddr;
        logic [MACDP_RPT_W-1:0]  rptCount;
        logic                    sameBlock;
        logic                    op2Single;
    } macdp_cmd_t;

    typedef struct packed {
        logic [31:0] acc;
        logic        carry;
        logic        ovf;
    } macdp_sum_t;
endpackage

// *** hw/macdp_fifo.sv ***
// result fifo with parameterised width and depth
`timescale 1ns/1ps
module macdp_fifo
    import macdp_pkg::*;
#(
    parameter int W = 32,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW:0]   wrPtr_reg;
    logic [AW:0]   rdPtr_reg;
    logic          doWr;
    logic          doRd;

    // full when pointers differ only in the wrap bit
    assign inReady  = !((wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                        (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]));
    assign outValid = (wrPtr_reg != rdPtr_reg);
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    assign outData  = mem[rdPtr_reg[AW-1:0]];

    // storage has no reset, only the pointers do
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_reg + (AW+1)'(doWr);
            rdPtr_reg <= rdPtr_reg + (AW+1)'(doRd);
        end
    end
endmodule

// *** hw/macdp_accum.sv ***
// product shifter and accumulator adder with carry, overflow and saturation
`timescale 1ns/1ps
module macdp_accum
    import macdp_pkg::*;
(
    input  wire logic [31:0] acc,
    input  wire logic [31:0] product,
    input  wire logic [1:0]  shiftMode,
    input  wire logic        satMode,
    output macdp_sum_t       result
);
    logic [31:0] shifted;
    logic [32:0] sum33;
    logic        ovf;

    // product output shifter
    always_comb begin
        case (shiftMode)
            MACDP_PM_NONE:   shifted = product;
            MACDP_PM_LEFT1:  shifted = {product[30:0], 1'b0};
            MACDP_PM_LEFT4:  shifted = {product[27:0], 4'h0};
            MACDP_PM_RIGHT6: shifted = 32'($signed(product) >>> 6);
            default:         shifted = product;
        endcase
    end

    // unsigned carry out, signed overflow when like signs give an unlike result
    assign sum33 = {1'b0, acc} + {1'b0, shifted};
    assign ovf   = (acc[31] == shifted[31]) && (sum33[31] != acc[31]);

    assign result.carry = sum33[32];
    assign result.ovf   = ovf;
    // saturate toward the sign of the operands
    assign result.acc   = (satMode && ovf) ? (acc[31] ? MACDP_NEG_MAX : MACDP_POS_MAX)
                                           : sum33[31:0];
endmodule

// *** tb/macdp_mem_model.sv ***
// program and data memory partner with optional stalls
`timescale 1ns/1ps
module macdp_mem_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [15:0] pmAddr,
    input  wire logic        pmRd,
    output logic [15:0]      pmData,
    output logic             pmRdy,
    input  wire logic [15:0] dmAddr,
    input  wire logic        dmRd,
    output logic [15:0]      dmData,
    output logic             dmRdy
);
    logic [15:0] lfsr = 16'h1ace;
    // stall pattern moves every cycle so a slow memory answers irregularly
    always @(posedge clk) lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13]};
    // program words come from any address
    assign pmRdy = pmRd && (!slow || lfsr[0]);
    assign dmRdy = dmRd && (!slow || lfsr[3]);
    // idle lines carry a changing pattern, never the last value
    assign pmData = pmRdy ? pmAddr * 16'h0013 + 16'h0007 : lfsr;
    assign dmData = dmRdy ? dmAddr ^ 16'h3c5a : ~lfsr;
endmodule

// *** tb/tb.sv ***
// self-checking bench of the multiply-accumulate datapath
`timescale 1ns/1ps
module tb;
    import macdp_pkg::*;
    logic        clk = 0, rst_b = 0, cmdValid = 0, resReady = 1, slow = 0;
    logic        satOn = 0, ovfClr = 0, auxWrEn = 0, overflowFlag, eV;
    logic [1:0]  productShiftMode = 0;
    logic [2:0]  auxWrIdx = 3'h0, auxRegPointer, eP = 3'h0;
    macdp_cmd_t  cmd = '0;
    logic [15:0] pmAddr, dmAddr, pmData, dmData, dmWrAddr, dmWrData, multiplicand, microStack;
    logic [15:0] auxWrData = 16'h0000, eA[8], daQ[$];
    logic        pmRd, pmRdy, dmRd, dmRdy, dmWrEn, resValid, cmdReady, carryFlag, done;
    logic [31:0] resData, accumulator, product, eAcc = 0, eProd = 0, expQ[$];
    logic [15:0] eMul, eDa;
    logic        eC;
    int          errors = 0, checks_done = 0, moves = 0, nRun = 0;
    always #2.5 clk = ~clk;
    macdp_core dut (.clk, .rst_b, .cmdValid, .cmd, .cmdReady, .productShiftMode,
        .overflowSaturateMode(satOn), .overflowClear(ovfClr), .auxWrEn, .auxWrIdx,
        .auxWrData, .pmAddr, .pmRd, .pmData, .pmRdy, .dmAddr, .dmRd, .dmData, .dmRdy,
        .dmWrEn, .dmWrAddr, .dmWrData, .resValid, .resReady, .resData, .accumulator, .product,
        .multiplicand, .carryFlag, .overflowFlag, .auxRegPointer, .microStack, .done);
    macdp_mem_model mem (.clk, .slow, .pmAddr, .pmRd, .pmData, .pmRdy, .dmAddr, .dmRd,
        .dmData, .dmRdy);
    function automatic logic [31:0] shp(logic [31:0] p, logic [1:0] m);
        return m == 2'h1 ? p << 1 : m == 2'h2 ? p << 4 : m == 2'h3 ? 32'($signed(p) >>> 6) : p;
    endfunction
    function automatic logic [15:0] brev(logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) r[i] = v[15-i];
        return r;
    endfunction
    // aux register after one indirect step, by update code
    function automatic logic [15:0] auxNext(logic [15:0] a, logic [15:0] a0, logic [2:0] u);
        return u == MACDP_AUX_DEC ? a - 16'h0001 : u == MACDP_AUX_INC ? a + 16'h0001
            : u == MACDP_AUX_SUB0 ? a - a0 : u == MACDP_AUX_ADD0 ? a + a0
            : u == MACDP_AUX_BRSUB ? brev(16'(brev(a) - brev(a0)))
            : u == MACDP_AUX_BRADD ? brev(16'(brev(a) + brev(a0))) : a;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // result stream, data moves, and random back-pressure while slow
    always @(posedge clk) begin
        if (resValid && resReady)
            chk("result", resData, expQ.size() > 0 ? expQ.pop_front() : 32'hxxxx_xxxx);
        if (dmWrEn) begin
            moves++;
            eDa = daQ.size() > 0 ? daQ.pop_front() : 16'hxxxx;
            chk("moveAddr", dmWrAddr, 16'(eDa + 16'h0001));
            chk("moveData", dmWrData, eDa ^ 16'h3c5a);
        end
        if (slow) resReady <= 1'($urandom);
    end
    task automatic run(macdp_op_t op, logic [8:0] pg, logic [7:0] repeat_instruction, logic [1:0] m,
                       logic sb, logic o2s);
        macdp_cmd_t  c0;
        logic [32:0] s;
        logic [31:0] sh;
        logic [15:0] da;
        logic        wrapped, sat;
        int          k, n, c, nm;
        c0 = '0;
        c0.op = op;
        c0.dataPage = pg;
        c0.dma = 7'($urandom);
        c0.pma = 16'($urandom);
        c0.instrAddr = 16'($urandom);
        c0.rptCount = repeat_instruction;
        c0.sameBlock = sb;
        c0.op2Single = o2s;
        // every third run addresses indirectly with random update and pointer codes
        c0.indirect = (nRun % 3 == 1);
        c0.auxUpdate = 3'($urandom);
        c0.loadPtr = 1'($urandom);
        c0.nextAux = 3'($urandom);
        sat = 1'($urandom);
        nRun++;
        n = repeat_instruction + 1;
        eV = 0;
        // aux registers are loaded while the core is idle
        if (c0.indirect) begin
            for (int j = 0; j < 8; j++) begin
                @(posedge clk);
                eA[j] = 16'h0300 + 16'($urandom % 64);
                auxWrEn <= 1;
                auxWrIdx <= 3'(j);
                auxWrData <= eA[j];
            end
        end
        // expected sums, loads, products, moves and aux walk pass by pass
        for (int i = 0; i < n; i++) begin
            da = c0.indirect ? eA[eP] : {pg, c0.dma};
            sh = shp(eProd, m);
            s = {1'b0, eAcc} + {1'b0, sh};
            wrapped = (eAcc[31] == sh[31]) && (s[31] != eAcc[31]);
            eV = eV | wrapped;
            eAcc = (sat && wrapped) ? (eAcc[31] ? MACDP_NEG_MAX : MACDP_POS_MAX) : s[31:0];
            eC = s[32];
            eMul = da ^ 16'h3c5a;
            eProd = $signed(eMul) * $signed(16'(c0.pma + 16'(i)) * 16'h0013 + 16'h0007);
            expQ.push_back(eAcc);
            if (op == MACDP_MUL_ACC_MOVE && da >= MACDP_RAM_LO && da <= MACDP_RAM_HI)
                daQ.push_back(da);
            if (c0.indirect) begin
                eA[eP] = auxNext(eA[eP], eA[0], c0.auxUpdate);
                if (c0.loadPtr) eP = c0.nextAux;
            end
        end
        nm = daQ.size();
        moves = 0;
        @(posedge clk);
        auxWrEn <= 0;
        ovfClr <= 1;
        satOn <= sat;
        cmd <= c0;
        cmdValid <= 1;
        productShiftMode <= m;
        @(posedge clk);
        cmdValid <= 0;
        ovfClr <= 0;
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (done !== 1'b1 && k < 5000);
        chk("finished", k < 5000, 1);
        c = repeat_instruction == 0 ? (sb ? 4 : 3) : (op == MACDP_MUL_ACC_MOVE && o2s) ? (sb ? 3 * n : 2 * n)
            : (sb ? 2 * n + 2 : n + 2);
        if (!slow) chk("cycles", k, c);
        chk("acc", accumulator, eAcc);
        chk("carry", carryFlag, eC);
        chk("mult", multiplicand, eMul);
        chk("prod", product, eProd);
        chk("stack", microStack, 16'(c0.instrAddr + MACDP_INSTR_LEN));
        chk("pc", pmAddr, 16'(c0.instrAddr + MACDP_INSTR_LEN));
        chk("ready", cmdReady, 1);
        chk("ovf", overflowFlag, eV);
        chk("auxPtr", auxRegPointer, eP);
        repeat (slow ? 100 : 3) @(posedge clk);
        chk("moves", moves, nm);
        chk("drained", expQ.size() + daQ.size(), 0);
        $display("test end op %0d passes %0d", op, n);
    endtask
    // corner cases first, then random traffic against a stalling memory
    initial begin
        void'($urandom(95));
        repeat (5) @(posedge clk);
        rst_b <= 1;
        run(MACDP_MUL_ACC, 9'h006, 8'h00, 2'h0, 0, 0);
        for (int m = 0; m < 4; m++) run(MACDP_MUL_ACC, 9'h006, 8'($urandom % 16), 2'(m), 0, 0);
        run(MACDP_MUL_ACC, 9'h006, 8'h00, 2'h1, 1, 1);
        run(MACDP_MUL_ACC, 9'h006, 8'h07, 2'h3, 1, 1);
        for (int b = 0; b < 4; b++) run(MACDP_MUL_ACC_MOVE, 9'h006, 8'h05, 2'h0, b[1], b[0]);
        run(MACDP_MUL_ACC_MOVE, 9'h000, 8'h03, 2'h2, 0, 0);
        slow <= 1;
        repeat (6) run(macdp_op_t'($urandom % 2), 9'($urandom % 16), 8'($urandom % 16),
                       2'($urandom), 0, 0);
        report_and_stop();
    end
    // hang guard well beyond the expected run length
    initial begin
        #400000;
        errors++;
        report_and_stop();
    end
endmodule
